// *** design/dsic_pkg.sv ***
// Package: register map, bit layout and carriers of the south display interrupt block
`default_nettype none
package dsic_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam logic [19:0] OFS_LIVE_STATUS = 20'hc4000;
  localparam logic [19:0] OFS_MASK = 20'hc4004;
  localparam logic [19:0] OFS_IDENTITY = 20'hc4008;
  localparam logic [19:0] OFS_ENABLE = 20'hc400c;
  localparam logic [19:0] OFS_HP_CTL = 20'hc4030;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_LIVE_STATUS = 32'h00000000;
  localparam logic [31:0] RST_MASK = 32'hfffedfff;
  localparam logic [31:0] RST_IDENTITY = 32'h00000000;
  localparam logic [31:0] RST_ENABLE = 32'h00000000;
  localparam logic [31:0] RST_HP_CTL = 32'h00000000;
  // ----------------------------------------------------------------
  // Interrupt bit positions
  // ----------------------------------------------------------------
  localparam int BIT_AUD_PWR_B = 25;
  localparam int BIT_GMBUS = 24;
  localparam int BIT_AUD_PROT_A = 20;
  localparam int BIT_POISON = 19;
  localparam int BIT_RX_B = 17;
  localparam int BIT_RX_A = 16;
  localparam int BIT_AUX_B = 13;
  localparam int BIT_ANALOG_HP = 11;
  localparam int BIT_DIG_HP_B = 8;
  localparam int BIT_EXT_VIDEO_HP = 6;
  localparam int BIT_TC_B_BASE = 3;
  localparam int BIT_TC_A_BASE = 0;
  localparam int TC_UNDERRUN = 0;
  localparam int TC_CRC_ERR = 1;
  localparam int TC_CRC_DONE = 2;
  // ----------------------------------------------------------------
  // Hot-plug control field layout (per port stride)
  // ----------------------------------------------------------------
  localparam int HP_PORTS = 3;
  localparam int HP_STRIDE = 8;
  localparam int HP_STS_OFS = 0;
  localparam int HP_DUR_OFS = 2;
  localparam int HP_EN_OFS = 4;
  localparam int HP_RSVD_LO = 21;
  localparam int RX_ID_W = 8;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] audio_pwr_chg;   // Pulses, index 0 = port B
    logic gmbus;                 // Pulse
    logic [1:0] audio_prot;      // Levels, index 0 = transcoder A
    logic poison;                // Pulse
    logic [RX_ID_W-1:0] rx_lane_a_identity;
    logic [RX_ID_W-1:0] rx_lane_b_identity;
    logic [2:0] aux_done;        // Pulses, index 0 = channel B
    logic analog_blue;
    logic analog_green;
    logic [2:0] hotplug_detect_line;
    logic [2:0] hp_short;        // Pulses from the pulse-width detector
    logic [2:0] hp_long;
    logic ext_video_hotplug_b;   // Level
    logic [1:0] crc_done;        // Pulses, index 0 = transcoder A
    logic [1:0] crc_mismatch;
    logic [1:0] fifo_underflow;  // Levels
  } dsic_src_s;
  typedef struct packed {
    logic req;
    logic write;
    logic [19:0] addr;
    logic [31:0] wdata;
  } dsic_mmio_req_s;
  typedef struct packed {
    logic rvalid;
    logic [31:0] rdata;
  } dsic_mmio_rsp_s;
endpackage : dsic_pkg
`default_nettype wire

// *** design/dsic_top.sv ***
// South display interrupt aggregation: live status, mask, identity, enable and hot-plug control
//
// Contract
// RULE_01 - Audio protection bits are levels while active
// RULE_02 - Poison message gives one pulse source
// RULE_03 - Receiver-lane combined bit is OR of identity
// RULE_04 - Aux done pulses for channels B, C, D
// RULE_05 - Analog hotplug ORs blue/green, latches any change
// RULE_06 - Digital hotplug follows line when enabled; latches detect
// RULE_07 - CRC done and mismatch pulses per transcoder
// RULE_08 - Underflow source stays high during underrun
// RULE_09 - Live status read-only, present conditions, reset zero
// RULE_10 - Software should not poll pulses via live status
// RULE_11 - Mask register read/write, zero reports, one blocks
// RULE_12 - Masked sources never set identity bits
// RULE_13 - Identity bits cleared only by writing one
// RULE_14 - Interrupt when identity and enable bits coincide
// RULE_15 - Disabled identity bits still latch for polling
// RULE_16 - Software reads identity first on interrupt
// RULE_17 - Hot-plug control read/write, top bits reserved zero
// RULE_18 - Detect status X1 short, 1X long, ORed
// RULE_19 - Latch same cycle; latch beats clear
`default_nettype none
module dsic_top
  import dsic_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register access
  input wire dsic_pkg::dsic_mmio_req_s mmio_req,
  output var dsic_pkg::dsic_mmio_rsp_s mmio_rsp,
  // Event sources
  input wire dsic_pkg::dsic_src_s src,
  // Hot-plug detector controls
  output logic [2:0] hp_detect_enable,
  output logic [5:0] hp_short_duration,
  // CPU interrupt
  output logic cpu_irq
);
  import dsic_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] identity_reg;
    logic [31:0] enable_reg;
    logic [2:0] hp_en;
    logic [2:0][1:0] hp_dur;
    logic [2:0][1:0] hp_sts;
    logic ana_prev;
    logic rvalid;
    logic [31:0] rdata;
    logic irq;
  } dsic_state_s;

  dsic_state_s st_r;
  dsic_state_s st_nxt;

  logic [31:0] live;
  logic [31:0] set_vec;
  logic [31:0] unmasked_set;
  logic [31:0] hp_rd;
  logic [2:0] hp_evt;
  logic ana_level;
  logic ana_evt;
  logic wr_en;
  logic rd_en;

  assign wr_en = mmio_req.req & mmio_req.write;
  assign rd_en = mmio_req.req & ~mmio_req.write;

  // ----------------------------------------------------------------
  // Per-port hot-plug detection and control readback
  // ----------------------------------------------------------------
  assign hp_rd[31:HP_RSVD_LO] = '0; // RULE_17
  genvar p;
  generate
    for (p = 0; p < HP_PORTS; p++) begin : g_hp
      // Detector pulses only count while the port's input buffer is on
      assign hp_evt[p] = (src.hp_short[p] | src.hp_long[p]) & st_r.hp_en[p]; // RULE_06
      assign hp_rd[p*HP_STRIDE+HP_STS_OFS +: 2] = st_r.hp_sts[p];
      assign hp_rd[p*HP_STRIDE+HP_DUR_OFS +: 2] = st_r.hp_dur[p];
      assign hp_rd[p*HP_STRIDE+HP_EN_OFS] = st_r.hp_en[p];
      if (p < HP_PORTS - 1) begin : g_rsvd
        assign hp_rd[p*HP_STRIDE+HP_EN_OFS+1 +: 3] = '0;
      end
    end
  endgenerate

  assign ana_level = src.analog_blue | src.analog_green; // RULE_05
  assign ana_evt = ana_level ^ st_r.ana_prev; // RULE_05

  // ----------------------------------------------------------------
  // Live status and set events
  // ----------------------------------------------------------------
  always_comb begin
    live = RST_LIVE_STATUS;
    live[BIT_AUD_PWR_B +: 3] = src.audio_pwr_chg;
    live[BIT_GMBUS] = src.gmbus;
    live[BIT_AUD_PROT_A +: 2] = src.audio_prot; // RULE_01
    live[BIT_POISON] = src.poison; // RULE_02
    live[BIT_RX_B] = |src.rx_lane_b_identity; // RULE_03
    live[BIT_RX_A] = |src.rx_lane_a_identity; // RULE_03
    live[BIT_AUX_B +: 3] = src.aux_done; // RULE_04
    live[BIT_ANALOG_HP] = ana_level; // RULE_05
    live[BIT_DIG_HP_B +: 3] = src.hotplug_detect_line & st_r.hp_en; // RULE_06
    live[BIT_EXT_VIDEO_HP] = src.ext_video_hotplug_b;
    live[BIT_TC_A_BASE+TC_UNDERRUN] = src.fifo_underflow[0]; // RULE_08
    live[BIT_TC_A_BASE+TC_CRC_ERR] = src.crc_mismatch[0]; // RULE_07
    live[BIT_TC_A_BASE+TC_CRC_DONE] = src.crc_done[0]; // RULE_07
    live[BIT_TC_B_BASE+TC_UNDERRUN] = src.fifo_underflow[1]; // RULE_08
    live[BIT_TC_B_BASE+TC_CRC_ERR] = src.crc_mismatch[1]; // RULE_07
    live[BIT_TC_B_BASE+TC_CRC_DONE] = src.crc_done[1]; // RULE_07
    // Hotplug identity bits latch on detection edges, not on the live level
    set_vec = live;
    set_vec[BIT_ANALOG_HP] = ana_evt; // RULE_05
    set_vec[BIT_DIG_HP_B +: 3] = hp_evt; // RULE_06
  end

  assign unmasked_set = set_vec & ~st_r.mask; // RULE_12

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] iir_clr;
    iir_clr = '0;
    st_nxt = st_r;
    st_nxt.ana_prev = ana_level;
    st_nxt.rvalid = rd_en;
    if (wr_en) begin
      if (mmio_req.addr == OFS_MASK) begin
        st_nxt.mask = mmio_req.wdata; // RULE_11
      end else if (mmio_req.addr == OFS_IDENTITY) begin
        iir_clr = mmio_req.wdata; // RULE_13
      end else if (mmio_req.addr == OFS_ENABLE) begin
        st_nxt.enable_reg = mmio_req.wdata;
      end else if (mmio_req.addr == OFS_HP_CTL) begin
        for (int i = 0; i < HP_PORTS; i++) begin
          st_nxt.hp_en[i] = mmio_req.wdata[i*HP_STRIDE+HP_EN_OFS];
          st_nxt.hp_dur[i] = mmio_req.wdata[i*HP_STRIDE+HP_DUR_OFS +: 2];
          st_nxt.hp_sts[i] = st_r.hp_sts[i] & ~mmio_req.wdata[i*HP_STRIDE+HP_STS_OFS +: 2];
        end
      end
    end
    // Detector status: bit 0 short, bit 1 long; a new detect beats a clear
    for (int i = 0; i < HP_PORTS; i++) begin
      if (src.hp_short[i] & st_r.hp_en[i]) begin
        st_nxt.hp_sts[i][0] = 1'b1; // RULE_18
      end
      if (src.hp_long[i] & st_r.hp_en[i]) begin
        st_nxt.hp_sts[i][1] = 1'b1; // RULE_18
      end
    end
    // Set terms are applied after the clear so a same-cycle event survives
    st_nxt.identity_reg = (st_r.identity_reg & ~iir_clr) | unmasked_set; // RULE_19
    st_nxt.irq = |(st_nxt.identity_reg & st_nxt.enable_reg); // RULE_14
    if (rd_en) begin
      if (mmio_req.addr == OFS_LIVE_STATUS) begin
        st_nxt.rdata = live; // RULE_09
      end else if (mmio_req.addr == OFS_MASK) begin
        st_nxt.rdata = st_r.mask;
      end else if (mmio_req.addr == OFS_IDENTITY) begin
        st_nxt.rdata = st_r.identity_reg; // RULE_15
      end else if (mmio_req.addr == OFS_ENABLE) begin
        st_nxt.rdata = st_r.enable_reg;
      end else if (mmio_req.addr == OFS_HP_CTL) begin
        st_nxt.rdata = hp_rd; // RULE_17
      end else begin
        st_nxt.rdata = '0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r.mask <= RST_MASK; // RULE_11
      st_r.identity_reg <= RST_IDENTITY;
      st_r.enable_reg <= RST_ENABLE;
      st_r.hp_en <= '0;
      st_r.hp_dur <= '0;
      st_r.hp_sts <= '0;
      st_r.ana_prev <= 1'b0;
      st_r.rvalid <= 1'b0;
      st_r.rdata <= RST_HP_CTL;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mmio_rsp.rvalid = st_r.rvalid;
  assign mmio_rsp.rdata = st_r.rdata;
  assign hp_detect_enable = st_r.hp_en;
  assign hp_short_duration = st_r.hp_dur;
  assign cpu_irq = st_r.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_mask_blocks: assert property (((st_r.identity_reg & ~$past(st_r.identity_reg)) & $past(st_r.mask)) == '0) // RULE_12
    else $error("masked source set an identity bit");
  chk_latch_same_cycle: assert property (unmasked_set != '0 |=> // RULE_19
      (st_r.identity_reg & $past(unmasked_set)) == $past(unmasked_set))
    else $error("unmasked event did not latch in the next cycle");
  chk_w1c_clear: assert property ((wr_en && mmio_req.addr == OFS_IDENTITY && unmasked_set == '0) |=> // RULE_13
      (st_r.identity_reg & $past(mmio_req.wdata)) == '0)
    else $error("identity bit survived a write of one");
  chk_w0_keeps: assert property ((wr_en && mmio_req.addr == OFS_IDENTITY) |=> // RULE_13
      (($past(st_r.identity_reg) & ~st_r.identity_reg) & ~$past(mmio_req.wdata)) == '0)
    else $error("identity bit lost without a one written");
  chk_irq_follows: assert property (cpu_irq == |(st_r.identity_reg & st_r.enable_reg)) // RULE_14
    else $error("interrupt output disagrees with identity and enable");
  chk_poll_latch: assert property ((unmasked_set != '0 && st_r.enable_reg == '0 && // RULE_15
      !(wr_en && mmio_req.addr == OFS_ENABLE)) |=> st_r.identity_reg != '0 ##0 !cpu_irq)
    else $error("disabled bit failed to latch or raised interrupt");
  chk_rx_combined: assert property (live[BIT_RX_A] == |src.rx_lane_a_identity && // RULE_03
      live[BIT_RX_B] == |src.rx_lane_b_identity)
    else $error("receiver-lane combined bit wrong");
  chk_hp_follow: assert property (live[BIT_DIG_HP_B] == (src.hotplug_detect_line[0] && st_r.hp_en[0])) // RULE_06
    else $error("digital hotplug live bit wrong");
  chk_analog_edge: assert property ((ana_evt && !st_r.mask[BIT_ANALOG_HP]) |=> st_r.identity_reg[BIT_ANALOG_HP]) // RULE_05
    else $error("analog hotplug change did not latch");
  chk_hpctl_rsvd: assert property ((rd_en && mmio_req.addr == OFS_HP_CTL) |=> // RULE_17
      mmio_rsp.rvalid && mmio_rsp.rdata[31:21] == '0)
    else $error("hot-plug reserved bits read non-zero");
  chk_short_status: assert property ((src.hp_short[1] && st_r.hp_en[1]) |=> st_r.hp_sts[1][0] ##1 1'b1) // RULE_18
    else $error("short pulse did not set status");

  // ----------------------------------------------------------------
  // Checks: register bus
  // ----------------------------------------------------------------
  // The bus never stalls, so every read is answered exactly one cycle later
  chk_read_answer: assert property (rd_en |=> mmio_rsp.rvalid) // RULE_09
    else $error("read request got no answer in the next cycle");
  chk_no_stray_answer: assert property (!rd_en |=> !mmio_rsp.rvalid) // RULE_09
    else $error("read answer without a read request");
  chk_live_rsvd: assert property ((rd_en && mmio_req.addr == OFS_LIVE_STATUS) |=> // RULE_09
      (mmio_rsp.rdata & 32'hf0c41080) == '0)
    else $error("reserved live status bit read non-zero");
  chk_rx_readback: assert property ((rd_en && mmio_req.addr == OFS_LIVE_STATUS) |=> // RULE_03
      mmio_rsp.rdata[BIT_RX_A] == $past(|src.rx_lane_a_identity) &&
      mmio_rsp.rdata[BIT_RX_B] == $past(|src.rx_lane_b_identity))
    else $error("receiver-lane combined bit read back wrong");
  chk_unmapped_zero: assert property ((rd_en && mmio_req.addr != OFS_LIVE_STATUS && // RULE_09
      mmio_req.addr != OFS_MASK && mmio_req.addr != OFS_IDENTITY &&
      mmio_req.addr != OFS_ENABLE && mmio_req.addr != OFS_HP_CTL) |=> mmio_rsp.rdata == '0)
    else $error("unmapped address read non-zero");
  chk_mask_write: assert property ((wr_en && mmio_req.addr == OFS_MASK) |=> // RULE_11
      st_r.mask == $past(mmio_req.wdata))
    else $error("mask write did not take");
  chk_mask_readback: assert property ((rd_en && mmio_req.addr == OFS_MASK) |=> // RULE_11
      mmio_rsp.rdata == $past(st_r.mask))
    else $error("mask read back wrong");
  chk_id_readback: assert property ((rd_en && mmio_req.addr == OFS_IDENTITY) |=> // RULE_15
      mmio_rsp.rdata == $past(st_r.identity_reg))
    else $error("identity read back wrong");
  chk_enable_write: assert property ((wr_en && mmio_req.addr == OFS_ENABLE) |=> // RULE_14
      st_r.enable_reg == $past(mmio_req.wdata))
    else $error("enable write did not take");
  chk_en_readback: assert property ((rd_en && mmio_req.addr == OFS_ENABLE) |=> // RULE_14
      mmio_rsp.rdata == $past(st_r.enable_reg))
    else $error("enable read back wrong");
  chk_live_ro: assert property ((wr_en && mmio_req.addr == OFS_LIVE_STATUS) |=> // RULE_09
      $stable(st_r.mask) && $stable(st_r.enable_reg) && $stable(hp_detect_enable))
    else $error("write to live status changed a register");
  chk_hp_en_write: assert property ((wr_en && mmio_req.addr == OFS_HP_CTL) |=> // RULE_17
      hp_detect_enable == {$past(mmio_req.wdata[20]), $past(mmio_req.wdata[12]), $past(mmio_req.wdata[4])})
    else $error("detect enable write did not take");
  chk_hp_dur_write: assert property ((wr_en && mmio_req.addr == OFS_HP_CTL) |=> // RULE_17
      hp_short_duration == {$past(mmio_req.wdata[19:18]), $past(mmio_req.wdata[11:10]),
      $past(mmio_req.wdata[3:2])})
    else $error("short pulse duration write did not take");
  chk_hp_sts_clear: assert property ((wr_en && mmio_req.addr == OFS_HP_CTL && // RULE_18
      mmio_req.wdata[1:0] == 2'h3 && !src.hp_short[0] && !src.hp_long[0]) |=> st_r.hp_sts[0] == 2'h0)
    else $error("detect status survived a write of ones");

  // ----------------------------------------------------------------
  // Checks: sources and interrupt
  // ----------------------------------------------------------------
  // Pulses are gone before software can read them, so the poison, aux done, CRC and digital hotplug pulses are checked at identity bits
  chk_prot_level: assert property ((src.audio_prot[1] && !st_r.mask[BIT_AUD_PROT_A+1]) |=> // RULE_01
      st_r.identity_reg[BIT_AUD_PROT_A+1])
    else $error("audio protection level did not latch");
  chk_poison_pulse: assert property ((src.poison && !st_r.mask[BIT_POISON]) |=> // RULE_02
      st_r.identity_reg[BIT_POISON])
    else $error("poison pulse did not latch");
  chk_rx_latch: assert property ((|src.rx_lane_b_identity && !st_r.mask[BIT_RX_B]) |=> // RULE_03
      st_r.identity_reg[BIT_RX_B])
    else $error("receiver-lane combined level did not latch");
  chk_aux_done: assert property ((src.aux_done[2] && !st_r.mask[BIT_AUX_B+2]) |=> // RULE_04
      st_r.identity_reg[BIT_AUX_B+2])
    else $error("aux done pulse did not latch");
  chk_aux_b: assert property ((src.aux_done[0] && !st_r.mask[BIT_AUX_B]) |=> // RULE_04
      st_r.identity_reg[BIT_AUX_B])
    else $error("aux done pulse did not latch");
  chk_analog_quiet: assert property ((ana_level == st_r.ana_prev && !st_r.identity_reg[BIT_ANALOG_HP]) |=> // RULE_05
      !st_r.identity_reg[BIT_ANALOG_HP])
    else $error("analog hotplug latched without a change");
  chk_dig_latch: assert property ((src.hp_short[1] && st_r.hp_en[1] && !st_r.mask[BIT_DIG_HP_B+1]) |=> // RULE_06
      st_r.identity_reg[BIT_DIG_HP_B+1])
    else $error("digital hotplug detect did not latch");
  chk_detect_off: assert property ((!st_r.hp_en[0] && !(wr_en && mmio_req.addr == OFS_HP_CTL)) |=> // RULE_06
      $stable(st_r.hp_sts[0]))
    else $error("detect status moved while the port is disabled");
  chk_crc_err: assert property ((src.crc_mismatch[1] && !st_r.mask[BIT_TC_B_BASE+TC_CRC_ERR]) |=> // RULE_07
      st_r.identity_reg[BIT_TC_B_BASE+TC_CRC_ERR])
    else $error("crc mismatch pulse did not latch");
  chk_crc_done: assert property ((src.crc_done[0] && !st_r.mask[BIT_TC_A_BASE+TC_CRC_DONE]) |=> // RULE_07
      st_r.identity_reg[BIT_TC_A_BASE+TC_CRC_DONE])
    else $error("crc done pulse did not latch");
  chk_underrun_hold: assert property ((src.fifo_underflow[0] && // RULE_08
      !st_r.mask[BIT_TC_A_BASE+TC_UNDERRUN]) |=> st_r.identity_reg[BIT_TC_A_BASE+TC_UNDERRUN])
    else $error("underrun level did not latch");
  chk_underrun_b: assert property ((src.fifo_underflow[1] && // RULE_08
      !st_r.mask[BIT_TC_B_BASE+TC_UNDERRUN]) |=> st_r.identity_reg[BIT_TC_B_BASE+TC_UNDERRUN])
    else $error("underrun level did not latch");
  chk_long_status: assert property ((src.hp_long[2] && st_r.hp_en[2]) |=> st_r.hp_sts[2][1]) // RULE_18
    else $error("long pulse did not set status");
  chk_irq_raise: assert property (((unmasked_set & st_r.enable_reg) != '0 && // RULE_14
      !(wr_en && mmio_req.addr == OFS_ENABLE)) |=> cpu_irq)
    else $error("enabled event did not raise the interrupt");
  chk_irq_drop: assert property ((wr_en && mmio_req.addr == OFS_IDENTITY && // RULE_13
      mmio_req.wdata == 32'hffffffff && unmasked_set == '0) |=> !cpu_irq)
    else $error("interrupt stayed up after every identity bit was cleared");

  cov_irq_raise: cover property (!cpu_irq ##1 cpu_irq);
  cov_clear_collide: cover property (wr_en && mmio_req.addr == OFS_IDENTITY && (unmasked_set & mmio_req.wdata) != '0);
  cov_hp_long: cover property (src.hp_long[2] && st_r.hp_en[2] ##1 st_r.identity_reg[BIT_DIG_HP_B+2]);
  cov_poll_only: cover property (unmasked_set != '0 && st_r.enable_reg == '0);
  cov_level_held: cover property (src.fifo_underflow[1] [*3]);
endmodule : dsic_top
`default_nettype wire

// *** verification/dsic_host.sv ***
// Host software model driving register reads and writes into the block
`default_nettype none
module dsic_host import dsic_pkg::*; (
  // Clock
  input wire logic clock,
  // Register access
  output var dsic_pkg::dsic_mmio_req_s mmio_req,
  input wire dsic_pkg::dsic_mmio_rsp_s mmio_rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  initial mmio_req = '0;
  // Idle lines show the inverse of the last value, so a stale address never passes for a held one
  task automatic wr(input logic [19:0] a, input logic [31:0] v);
    @(posedge clock);
    mmio_req <= '{1'b1, 1'b1, a, v};
    @(posedge clock);
    mmio_req <= '{1'b0, 1'b0, ~a, ~v};
  endtask : wr
  // Pulse sources are never polled in live status; identity is read first on an interrupt
  task automatic rd(input logic [19:0] a, output logic [31:0] v);
    @(posedge clock);
    mmio_req <= '{1'b1, 1'b0, a, 32'h0};
    @(posedge clock);
    mmio_req <= '{1'b0, 1'b0, ~a, 32'hffffffff};
    @(posedge clock);
    v = (mmio_rsp.rvalid === 1'b1) ? mmio_rsp.rdata : 'x;
  endtask : rd
endmodule : dsic_host
`default_nettype wire

// *** verification/tb.sv ***
// Testbench: register map, source latching, masking and interrupt output
`default_nettype none
module tb import dsic_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock;
  logic rst_b;
  dsic_src_s src;
  dsic_mmio_req_s mmio_req;
  dsic_mmio_rsp_s mmio_rsp;
  logic [2:0] hp_detect_enable;
  logic [5:0] hp_short_duration;
  logic cpu_irq;
  int failures;
  int compares;
  dsic_src_s s [10];
  logic [31:0] e [10];

  dsic_top uut (.clock(clock), .rst_b(rst_b), .mmio_req(mmio_req), .mmio_rsp(mmio_rsp), .src(src),
    .hp_detect_enable(hp_detect_enable), .hp_short_duration(hp_short_duration), .cpu_irq(cpu_irq));
  dsic_host host (.clock(clock), .mmio_req(mmio_req), .mmio_rsp(mmio_rsp));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [19:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask : rdchk

  // One cycle of the given sources, then all quiet
  task automatic pulse(input dsic_src_s v);
    @(posedge clock);
    src <= v;
    @(posedge clock);
    src <= '0;
  endtask : pulse

  task automatic give_verdict();
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Whole run needs under a microsecond
  initial begin
    #50us;
    failures++;
    give_verdict();
  end

  initial begin
    rst_b = 1'b0;
    src = '0;
    foreach (s[i]) s[i] = '0;
    s[0].poison = 1'b1;
    s[1].aux_done = 3'b111;
    s[2].crc_done = 2'b11;
    s[2].crc_mismatch = 2'b11;
    s[3].audio_pwr_chg = 3'b111;
    s[3].gmbus = 1'b1;
    s[4].audio_prot = 2'b11;
    s[4].fifo_underflow = 2'b11;
    s[5].rx_lane_a_identity = 8'h80;
    s[5].rx_lane_b_identity = 8'h01;
    s[6].analog_green = 1'b1;
    s[7].hp_short = 3'b001;
    s[7].hp_long = 3'b100;
    s[8].ext_video_hotplug_b = 1'b1;
    s[9].hotplug_detect_line = 3'b111;
    e = '{32'h00080000, 32'h0000e000, 32'h00000036, 32'h0f000000, 32'h00300009,
          32'h00030000, 32'h00000800, 32'h00000500, 32'h00000040, 32'h00000000};
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    // ----------------------------------------------------------------
    // Reset values and one hole in the map
    // ----------------------------------------------------------------
    chk({31'h0, cpu_irq}, 32'h0);
    rdchk(OFS_LIVE_STATUS, 32'h0);
    rdchk(OFS_MASK, 32'hfffedfff);
    rdchk(OFS_IDENTITY, 32'h0);
    rdchk(OFS_ENABLE, 32'h0);
    rdchk(OFS_HP_CTL, 32'h0);
    rdchk(20'hc4010, 32'h0);
    host.wr(OFS_MASK, 32'h0);
    rdchk(OFS_MASK, 32'h0);
    host.wr(OFS_ENABLE, 32'hffffffff);
    rdchk(OFS_ENABLE, 32'hffffffff);
    host.wr(OFS_HP_CTL, 32'h00101010);
    // ----------------------------------------------------------------
    // Table of sources against the identity bits they set
    // ----------------------------------------------------------------
    for (int i = 0; i < 10; i++) begin
      pulse(s[i]);
      rdchk(OFS_IDENTITY, e[i]);
      chk({31'h0, cpu_irq}, {31'h0, e[i] != 32'h0});
      host.wr(OFS_IDENTITY, 32'hffffffff);
    end
    // ----------------------------------------------------------------
    // Hot-plug status, reserved bits and detector controls
    // ----------------------------------------------------------------
    rdchk(OFS_HP_CTL, 32'h00121011);
    host.wr(OFS_HP_CTL, 32'hffffffff);
    rdchk(OFS_HP_CTL, 32'h001c1c1c);
    chk({23'h0, hp_short_duration, hp_detect_enable}, 32'h000001ff);
    // ----------------------------------------------------------------
    // Held levels: live view, read-only status, latch beats clear
    // ----------------------------------------------------------------
    @(posedge clock);
    src.audio_prot <= 2'b10;
    src.fifo_underflow <= 2'b10;
    src.rx_lane_a_identity <= 8'h01;
    src.hotplug_detect_line <= 3'b010;
    rdchk(OFS_LIVE_STATUS, 32'h00210208);
    host.wr(OFS_LIVE_STATUS, 32'h0);
    host.wr(OFS_IDENTITY, 32'hffffffff);
    rdchk(OFS_LIVE_STATUS, 32'h00210208);
    rdchk(OFS_IDENTITY, 32'h00210008);
    @(posedge clock);
    src <= '0;
    host.wr(OFS_IDENTITY, 32'h0);
    rdchk(OFS_IDENTITY, 32'h00210008);
    host.wr(OFS_IDENTITY, 32'hffffffff);
    rdchk(OFS_IDENTITY, 32'h0);
    // ----------------------------------------------------------------
    // Masking, polling without interrupt, interrupt latency
    // ----------------------------------------------------------------
    host.wr(OFS_MASK, 32'h00080000);
    pulse(s[0]);
    rdchk(OFS_IDENTITY, 32'h0);
    chk({31'h0, cpu_irq}, 32'h0);
    host.wr(OFS_MASK, 32'h0);
    host.wr(OFS_ENABLE, 32'hfff7ffff);
    pulse(s[0]);
    rdchk(OFS_IDENTITY, 32'h00080000);
    chk({31'h0, cpu_irq}, 32'h0);
    host.wr(OFS_IDENTITY, 32'h00080000);
    host.wr(OFS_ENABLE, 32'h0);
    pulse(s[1]);
    rdchk(OFS_IDENTITY, 32'h0000e000);
    chk({31'h0, cpu_irq}, 32'h0);
    host.wr(OFS_IDENTITY, 32'hffffffff);
    host.wr(OFS_ENABLE, 32'h00080000);
    // Interrupt follows the source by one edge; look half a cycle after each edge
    @(posedge clock);
    src.poison <= 1'b1;
    @(negedge clock);
    chk({31'h0, cpu_irq}, 32'h0);
    @(posedge clock);
    src.poison <= 1'b0;
    @(negedge clock);
    chk({31'h0, cpu_irq}, 32'h1);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
